// [rtl/general_protection_function.sv]
// Multipurpose protection decision logic with a Wishbone register file.
// Assumes magnitudes, cosine and angle come from same-clock pre-processing.
`timescale 1ns/1ps
`default_nettype none
`include "gpf_defines.svh"
module general_protection_function #(
  parameter int TICK_CYCLES = `GPF_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [15:0] currPh1,
  input wire logic [15:0] currPh2,
  input wire logic [15:0] currPh3,
  input wire logic [15:0] currPos,
  input wire logic [15:0] currNeg,
  input wire logic [15:0] currZero3,
  input wire logic [15:0] voltPh1,
  input wire logic [15:0] voltPh2,
  input wire logic [15:0] voltPh3,
  input wire logic [15:0] voltPos,
  input wire logic [15:0] voltNeg,
  input wire logic [15:0] voltZero3,
  input wire logic [15:0] curr2ndHarm,
  input wire logic [15:0] cosAngle,
  input wire logic [15:0] angleIn,
  input wire logic globalBlock,
  input wire logic overcurrent1Block,
  input wire logic overcurrent1TripBlock,
  input wire logic overcurrent1MultiplierEnable,
  input wire logic overcurrent2Block,
  input wire logic overcurrent2TripBlock,
  input wire logic overcurrent2MultiplierEnable,
  input wire logic undercurrent1Block,
  input wire logic undercurrent1TripBlock,
  input wire logic undercurrent2Block,
  input wire logic undercurrent2TripBlock,
  input wire logic overvoltage1Block,
  input wire logic overvoltage1TripBlock,
  input wire logic overvoltage2Block,
  input wire logic overvoltage2TripBlock,
  input wire logic undervoltage1Block,
  input wire logic undervoltage1TripBlock,
  input wire logic undervoltage2Block,
  input wire logic undervoltage2TripBlock,
  output logic commonTrip,
  output logic commonStart,
  output logic overcurrent1Trip,
  output logic overcurrent2Trip,
  output logic undercurrent1Trip,
  output logic undercurrent2Trip,
  output logic overvoltage1Trip,
  output logic overvoltage2Trip,
  output logic undervoltage1Trip,
  output logic undervoltage2Trip,
  output logic overcurrent1Start,
  output logic overcurrent2Start,
  output logic undercurrent1Start,
  output logic undercurrent2Start,
  output logic overvoltage1Start,
  output logic overvoltage2Start,
  output logic undervoltage1Start,
  output logic undervoltage2Start,
  output logic harmonicRestraintFlag,
  output gpf_pkg::dir_mode_type overcurrent1DirectionMode,
  output gpf_pkg::dir_mode_type overcurrent2DirectionMode,
  output logic polarizingVoltageLow,
  output logic [15:0] measuredCurrent,
  output logic [15:0] currentCosineProduct,
  output logic [15:0] measuredVoltage,
  output logic [15:0] voltageCurrentAngle
);
  import gpf_pkg::*;

  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

  top_state_type s, next_s;
  logic [7:0] stepStart;
  logic [7:0] stepTrip;
  logic [7:0] stepBlock;
  logic [7:0] stepTripBlock;
  logic [7:0] stepPermit;
  logic [7:0][15:0] stepMeasure;
  logic [7:0][15:0] stepPickup;
  logic [1:0] multEnable;
  logic stepClear;
  logic [15:0] selCurr, selVolt, selRestr;
  logic [31:0] wrWord;
  logic [31:0] rdWord;
  logic signed [32:0] icosProd;
  logic [31:0] harmLhs, harmRhs, restrLhs, restrRhs;
  logic restrOk;

  // Magnitude selection shared by current and voltage
  function automatic logic [15:0] select_mag(input meas_sel_type sel, input logic [15:0] p1,
    input logic [15:0] p2, input logic [15:0] p3, input logic [15:0] pos,
    input logic [15:0] neg, input logic [15:0] zero);
    logic [15:0] mx;
    logic [15:0] mn;
    mx = (p1 > p2) ? p1 : p2;
    mx = (mx > p3) ? mx : p3;
    mn = (p1 < p2) ? p1 : p2;
    mn = (mn < p3) ? mn : p3;
    unique case (sel)
      SEL_PH1: select_mag = p1;
      SEL_PH2: select_mag = p2;
      SEL_PH3: select_mag = p3;
      SEL_POS: select_mag = pos;
      SEL_NEG: select_mag = neg;
      SEL_ZERO3: select_mag = zero;
      SEL_MAXPH: select_mag = mx;
      SEL_MINPH: select_mag = mn;
    endcase
  endfunction

  // Byte-lane merge of a Wishbone write
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
    input logic [3:0] sel);
    merge_bytes = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge_bytes[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction

  // Direction mode field, illegal code treated as non-directional
  function automatic dir_mode_type dir_field(input logic [1:0] f);
    dir_field = (f == 2'h3) ? DIR_NONDIR : dir_mode_type'(f);
  endfunction

  // Direction check on the registered cosine sign
  function automatic logic dir_ok(input dir_mode_type m, input logic polLow,
    input logic [15:0] cosv);
    unique case (m)
      DIR_FORWARD: dir_ok = !polLow && !cosv[15] && (cosv != 16'h0);
      DIR_REVERSE: dir_ok = !polLow && cosv[15];
      default: dir_ok = 1'b1;
    endcase
  endfunction

  // Quantity selection
  always_comb begin
    selCurr = select_mag(meas_sel_type'(s.ctrl[`GPF_CTRL_CURR_SEL +: 3]), currPh1, currPh2,
      currPh3, currPos, currNeg, currZero3);
    selVolt = select_mag(meas_sel_type'(s.ctrl[`GPF_CTRL_VOLT_SEL +: 3]), voltPh1, voltPh2,
      voltPh3, voltPos, voltNeg, voltZero3);
    unique case (restr_sel_type'(s.ctrl[`GPF_CTRL_RESTR_SEL +: 2]))
      RSEL_POS: selRestr = currPos;
      RSEL_NEG: selRestr = currNeg;
      RSEL_ZERO3: selRestr = currZero3;
      RSEL_MAX: selRestr = select_mag(SEL_MAXPH, currPh1, currPh2, currPh3, currPos, currNeg,
        currZero3);
    endcase
  end

  // Register read mux
  always_comb begin
    rdWord = '0;
    if (adr_i[7:4] >= `GPF_STEP_BASE_HI && adr_i[7:4] < 4'(`GPF_STEP_BASE_HI + 8)) begin
      unique case (adr_i[3:0])
        `GPF_STEP_LEVEL_LO: rdWord = s.stepLevel[3'(adr_i[7:4] - `GPF_STEP_BASE_HI)];
        `GPF_STEP_TIME_LO: rdWord = s.stepTime[3'(adr_i[7:4] - `GPF_STEP_BASE_HI)];
        `GPF_STEP_MODE_LO: rdWord = 32'(s.stepMode[3'(adr_i[7:4] - `GPF_STEP_BASE_HI)]);
        default: rdWord = '0;
      endcase
    end else begin
      unique case (adr_i)
        `GPF_ADR_CTRL: rdWord = s.ctrl;
        `GPF_ADR_LIMITS: rdWord = s.limits;
        `GPF_ADR_STATUS: rdWord = {12'h0, s.polLow, s.harmFlag, s.commonTrip, s.commonStart,
          stepTrip, stepStart};
        `GPF_ADR_MEAS: rdWord = {s.measVolt, s.measCurr};
        `GPF_ADR_ANGLE: rdWord = {s.icos, s.angle};
        `GPF_ADR_MULT: rdWord = s.mult;
        default: rdWord = '0;
      endcase
    end
  end

  assign wrWord = merge_bytes(rdWord, dat_i, sel_i);

  // Second harmonic and restraint comparisons in percent
  assign harmLhs = 32'(s.harmMag) * 32'h64;
  assign harmRhs = 32'(s.limits[7:0]) * 32'(s.measCurr);
  assign restrLhs = 32'(s.measCurr) * 32'h64;
  assign restrRhs = 32'(s.limits[15:8]) * 32'(s.measRestr);
  assign restrOk = !s.ctrl[`GPF_CTRL_RESTR_EN] || (restrLhs >= restrRhs);
  assign icosProd = $signed({1'b0, s.measCurr}) * $signed(s.cosVal);

  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    // Wishbone slave, one wait state, unmapped reads zero
    if (cyc_i && stb_i && !s.ack) begin
      next_s.ack = 1'b1;
      next_s.rdData = rdWord;
      if (we_i) begin
        if (adr_i[7:4] >= `GPF_STEP_BASE_HI && adr_i[7:4] < 4'(`GPF_STEP_BASE_HI + 8)) begin
          unique case (adr_i[3:0])
            `GPF_STEP_LEVEL_LO:
              next_s.stepLevel[3'(adr_i[7:4] - `GPF_STEP_BASE_HI)] = wrWord;
            `GPF_STEP_TIME_LO:
              next_s.stepTime[3'(adr_i[7:4] - `GPF_STEP_BASE_HI)] = wrWord;
            `GPF_STEP_MODE_LO:
              next_s.stepMode[3'(adr_i[7:4] - `GPF_STEP_BASE_HI)] = wrWord[1:0] & `GPF_MODE_MASK;
            default: ;
          endcase
        end else begin
          unique case (adr_i)
            `GPF_ADR_CTRL: next_s.ctrl = wrWord & `GPF_CTRL_MASK;
            `GPF_ADR_LIMITS: next_s.limits = wrWord;
            `GPF_ADR_MULT: next_s.mult = {16'h0, wrWord[15:0]};
            default: ;
          endcase
        end
      end
    end
    next_s.msTick = (s.tickCnt == TICK_LAST);
    next_s.tickCnt = next_s.msTick ? 18'h0 : s.tickCnt + 18'h1;
    next_s.measCurr = selCurr;
    next_s.measVolt = selVolt;
    next_s.measRestr = selRestr;
    next_s.harmMag = curr2ndHarm;
    next_s.cosVal = cosAngle;
    next_s.angle = angleIn;
    next_s.icos = icosProd[30:15];
    next_s.harmFlag = s.ctrl[`GPF_CTRL_HARM_EN] && (harmLhs > harmRhs);
    next_s.polLow = s.measVolt < s.limits[31:16];
    next_s.dirMode[0] = dir_field(s.ctrl[`GPF_CTRL_OC1_DIR +: 2]);
    next_s.dirMode[1] = dir_field(s.ctrl[`GPF_CTRL_OC2_DIR +: 2]);
    for (int k = 0; k < 2; k++) begin
      next_s.ocPermit[k] = restrOk && !s.harmFlag &&
        dir_ok(dir_mode_type'(s.dirMode[k]), s.polLow, s.cosVal);
    end
    next_s.commonStart = |stepStart;
    next_s.commonTrip = |stepTrip;
    if (stepClear) begin
      next_s.commonStart = 1'b0;
      next_s.commonTrip = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.ctrl <= `GPF_CTRL_RESET;
      s.limits <= `GPF_LIMITS_RESET;
      s.mult <= `GPF_MULT_RESET;
      s.stepLevel <= {{2{`GPF_RATIO_UNDER, 16'h0}}, {2{`GPF_RATIO_OVER, 16'h0}},
        {2{`GPF_RATIO_UNDER, 16'h0}}, {2{`GPF_RATIO_OVER, 16'h0}}};
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign stepClear = globalBlock || !s.ctrl[`GPF_CTRL_OPER];
  assign multEnable = {overcurrent2MultiplierEnable, overcurrent1MultiplierEnable};
  assign stepBlock = {undervoltage2Block, undervoltage1Block, overvoltage2Block,
    overvoltage1Block, undercurrent2Block, undercurrent1Block, overcurrent2Block,
    overcurrent1Block};
  assign stepTripBlock = {undervoltage2TripBlock, undervoltage1TripBlock, overvoltage2TripBlock,
    overvoltage1TripBlock, undercurrent2TripBlock, undercurrent1TripBlock,
    overcurrent2TripBlock, overcurrent1TripBlock};

  // Steps 0-1 overcurrent, 2-3 undercurrent, 4-5 overvoltage, 6-7 undervoltage
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : gStep
      logic [23:0] multProd;
      assign multProd = 24'(s.stepLevel[i][15:0]) * 24'(s.mult[(i % 2) * 8 +: 8]);
      if (i < 2) begin : gOc
        // Multiplier is 4.4 fixed point
        assign stepPickup[i] = multEnable[i] ?
          ((multProd[23:20] != 4'h0) ? 16'hFFFF : multProd[19:4]) : s.stepLevel[i][15:0];
        assign stepPermit[i] = s.ocPermit[i];
      end else begin : gOther
        assign stepPickup[i] = s.stepLevel[i][15:0];
        assign stepPermit[i] = 1'b1;
      end
      assign stepMeasure[i] = (i < 4) ? s.measCurr : s.measVolt;
      protection_step #(
        .UNDER((i == 2) || (i == 3) || (i == 6) || (i == 7)),
        .INVERSE_OK((i != 2) && (i != 3))
      ) uStep (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .msTick(s.msTick),
        .clear(stepClear),
        .enable(s.stepMode[i][0]),
        .inverse(s.stepMode[i][1]),
        .block(stepBlock[i]),
        .tripBlock(stepTripBlock[i]),
        .permit(stepPermit[i]),
        .measure(stepMeasure[i]),
        .pickup(stepPickup[i]),
        .ratio(s.stepLevel[i][31:16]),
        .opDelay(s.stepTime[i][15:0]),
        .rstDelay(s.stepTime[i][31:16]),
        .start(stepStart[i]),
        .trip(stepTrip[i])
      );
    end
  endgenerate

  assign dat_o = s.rdData;
  assign ack_o = s.ack;
  assign commonStart = s.commonStart;
  assign commonTrip = s.commonTrip;
  assign overcurrent1Start = stepStart[0];
  assign overcurrent2Start = stepStart[1];
  assign undercurrent1Start = stepStart[2];
  assign undercurrent2Start = stepStart[3];
  assign overvoltage1Start = stepStart[4];
  assign overvoltage2Start = stepStart[5];
  assign undervoltage1Start = stepStart[6];
  assign undervoltage2Start = stepStart[7];
  assign overcurrent1Trip = stepTrip[0];
  assign overcurrent2Trip = stepTrip[1];
  assign undercurrent1Trip = stepTrip[2];
  assign undercurrent2Trip = stepTrip[3];
  assign overvoltage1Trip = stepTrip[4];
  assign overvoltage2Trip = stepTrip[5];
  assign undervoltage1Trip = stepTrip[6];
  assign undervoltage2Trip = stepTrip[7];
  assign harmonicRestraintFlag = s.harmFlag;
  assign overcurrent1DirectionMode = dir_mode_type'(s.dirMode[0]);
  assign overcurrent2DirectionMode = dir_mode_type'(s.dirMode[1]);
  assign polarizingVoltageLow = s.polLow;
  assign measuredCurrent = s.measCurr;
  assign currentCosineProduct = s.icos;
  assign measuredVoltage = s.measVolt;
  assign voltageCurrentAngle = s.angle;
endmodule
`default_nettype wire

// [rtl/gpf_defines.svh]
// Offsets, field positions, reset values and timing counts of the protection block.
// Assumes a 32-bit classic Wishbone slave with byte addresses on adr_i.
//
// Behaviour
// - Two identical overvoltage and two undervoltage steps, each with own settings.
// - Overvoltage step starts when selected voltage exceeds its pickup level.
// - Overvoltage drop-out uses a settable reset ratio, default 0.99.
// - Undervoltage step starts when selected voltage falls below its pickup.
// - Undervoltage drop-out uses a settable reset ratio, default 1.01.
// - Overvoltage start runs definite or inverse delay; trip after the delay.
// - Undervoltage start runs definite or inverse delay; trip after the delay.
// - Start and trip drop immediately or after a per-step reset timer.
// - Configuration picks measured current, measured voltage and restraint current.
// - Each step decides alone from shared quantities and its own settings.
// - Common start is OR of step starts; common trip OR of step trips.
// - Per-step trip block suppresses trip while start may still assert.
// - Overcurrent multiplier enable scales that step's current pickup level.
// - Start and trip flags are output for all eight steps.
// - A flag shows second-harmonic restraint blocking.
// - Each overcurrent step outputs its directional mode.
// - A flag shows polarizing voltage too low for direction.
// - Outputs measured current, current times cosine, voltage and angle.
// - Undercurrent starts below pickup and uses definite delay only.
// - Active restraint stops overcurrent start below set percent of restraint current.
`ifndef GPF_DEFINES_SVH
`define GPF_DEFINES_SVH

`define GPF_CLK_PERIOD_NS 4
`define GPF_TICK_PERIOD_NS 1000000
`define GPF_TICK_CYCLES (`GPF_TICK_PERIOD_NS / `GPF_CLK_PERIOD_NS)

`define GPF_ADR_CTRL 8'h00
`define GPF_ADR_LIMITS 8'h04
`define GPF_ADR_STATUS 8'h08
`define GPF_ADR_MEAS 8'h0C
`define GPF_ADR_ANGLE 8'h10
`define GPF_ADR_MULT 8'h14
`define GPF_STEP_BASE_HI 4'h4
`define GPF_STEP_LEVEL_LO 4'h0
`define GPF_STEP_TIME_LO 4'h4
`define GPF_STEP_MODE_LO 4'h8

`define GPF_CTRL_OPER 0
`define GPF_CTRL_HARM_EN 1
`define GPF_CTRL_RESTR_EN 2
`define GPF_CTRL_CURR_SEL 4
`define GPF_CTRL_VOLT_SEL 8
`define GPF_CTRL_RESTR_SEL 12
`define GPF_CTRL_OC1_DIR 16
`define GPF_CTRL_OC2_DIR 18
`define GPF_CTRL_MASK 32'h000F3777
`define GPF_MODE_MASK 2'h3
`define GPF_RATIO_FRAC_BITS 10

`define GPF_CTRL_RESET 32'h00002660
`define GPF_LIMITS_RESET 32'h000A1414
`define GPF_MULT_RESET 32'h00001010
`define GPF_RATIO_OVER 16'h03F6
`define GPF_RATIO_UNDER 16'h040A

`endif

// [rtl/gpf_pkg.sv]
// Types of the protection block: selector codes, step states and register state.
// Assumes gpf_defines.svh is compiled alongside.
package gpf_pkg;

  typedef enum logic [2:0] {
    SEL_PH1 = 3'h0, SEL_PH2 = 3'h1, SEL_PH3 = 3'h2, SEL_POS = 3'h3,
    SEL_NEG = 3'h4, SEL_ZERO3 = 3'h5, SEL_MAXPH = 3'h6, SEL_MINPH = 3'h7
  } meas_sel_type;

  typedef enum logic [1:0] {
    RSEL_POS = 2'h0, RSEL_NEG = 2'h1, RSEL_ZERO3 = 2'h2, RSEL_MAX = 2'h3
  } restr_sel_type;

  typedef enum logic [1:0] {
    DIR_NONDIR = 2'h0, DIR_FORWARD = 2'h1, DIR_REVERSE = 2'h2
  } dir_mode_type;

  typedef enum logic [1:0] {
    STEP_IDLE = 2'h0, STEP_RUN = 2'h1, STEP_OPERATED = 2'h3, STEP_RESETTING = 2'h2
  } step_phase_type;

  typedef struct packed {
    step_phase_type ph;
    logic operated;
    logic [31:0] timer;
    logic [15:0] rstTimer;
    logic start;
    logic trip;
  } step_state_type;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] limits;
    logic [31:0] mult;
    logic [7:0][31:0] stepLevel;
    logic [7:0][31:0] stepTime;
    logic [7:0][1:0] stepMode;
    logic ack;
    logic [31:0] rdData;
    logic [17:0] tickCnt;
    logic msTick;
    logic [15:0] measCurr;
    logic [15:0] measVolt;
    logic [15:0] measRestr;
    logic [15:0] harmMag;
    logic [15:0] cosVal;
    logic [15:0] angle;
    logic [15:0] icos;
    logic harmFlag;
    logic polLow;
    logic [1:0] ocPermit;
    logic [1:0][1:0] dirMode;
    logic commonStart;
    logic commonTrip;
  } top_state_type;

endpackage

// [rtl/protection_step.sv]
// One protection step: pickup with hysteresis, operate timer, reset timer.
// Assumes a one-cycle msTick pulse and same-clock inputs.
`timescale 1ns/1ps
`default_nettype none
`include "gpf_defines.svh"
module protection_step #(
  parameter bit UNDER = 1'b0,
  parameter bit INVERSE_OK = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic msTick,
  input wire logic clear,
  input wire logic enable,
  input wire logic inverse,
  input wire logic block,
  input wire logic tripBlock,
  input wire logic permit,
  input wire logic [15:0] measure,
  input wire logic [15:0] pickup,
  input wire logic [15:0] ratio,
  input wire logic [15:0] opDelay,
  input wire logic [15:0] rstDelay,
  output logic start,
  output logic trip
);
  import gpf_pkg::*;

  step_state_type s, n;
  logic [31:0] dropProd;
  logic [31:0] invLimit;
  logic [31:0] measScaled;
  logic [15:0] excess;
  logic pickCond, holdCond, cond, useInv;

  assign dropProd = 32'(pickup) * 32'(ratio);
  assign measScaled = 32'(measure) << `GPF_RATIO_FRAC_BITS;
  assign invLimit = 32'(opDelay) * 32'(pickup);
  assign useInv = INVERSE_OK && inverse;

  always_comb begin
    pickCond = UNDER ? (measure < pickup) : (measure > pickup);
    holdCond = UNDER ? (measScaled < dropProd) : (measScaled > dropProd);
    excess = '0;
    if (pickCond) begin
      excess = UNDER ? pickup - measure : measure - pickup;
    end
    cond = permit && ((s.ph == STEP_IDLE) ? pickCond : holdCond);
  end

  always_comb begin
    n = s;
    if (clear || !enable || block) begin
      n = '0;
    end else begin
      unique case (s.ph)
        STEP_IDLE: begin
          if (cond) begin
            n.ph = STEP_RUN;
            n.timer = '0;
          end
        end
        STEP_RUN, STEP_OPERATED: begin
          if (!cond) begin
            if (rstDelay == 16'h0) begin
              n = '0;
            end else begin
              n.ph = STEP_RESETTING;
              n.rstTimer = '0;
            end
          end else if (s.ph == STEP_RUN && msTick) begin
            // Inverse mode integrates excess; trips sooner for larger excess
            n.timer = s.timer + (useInv ? 32'(excess) : 32'h1);
            if (n.timer >= (useInv ? invLimit : 32'(opDelay))) begin
              n.ph = STEP_OPERATED;
              n.operated = 1'b1;
            end
          end
        end
        STEP_RESETTING: begin
          if (cond) begin
            n.ph = s.operated ? STEP_OPERATED : STEP_RUN;
          end else if (msTick) begin
            n.rstTimer = s.rstTimer + 16'h1;
            if (n.rstTimer >= rstDelay) begin
              n = '0;
            end
          end
        end
      endcase
    end
    n.start = (n.ph != STEP_IDLE);
    n.trip = n.operated && !tripBlock && (n.ph != STEP_IDLE);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  assign start = s.start;
  assign trip = s.trip;
endmodule
`default_nettype wire

// [sim/general_protection_function_tb.sv]
// Bench for the protection block: registers, voltage steps and blocking.
// Assumes preproc_model as the measurement source and a 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module general_protection_function_tb;
  import gpf_pkg::*;
  logic clk, arst_n, ce, cyc_i, stb_i, we_i, ack_o, globalBlock;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o, q;
  logic [3:0] sel_i;
  logic [17:0] blk;
  logic [15:0] vLevel, cLevel, currPh1, currPh2, currPh3, currPos, currNeg, currZero3;
  logic [15:0] voltPh1, voltPh2, voltPh3, voltPos, voltNeg, voltZero3, curr2ndHarm;
  logic [15:0] cosAngle, angleIn, measuredCurrent, measuredVoltage;
  logic commonTrip, commonStart, overvoltage1Trip, overvoltage1Start, undervoltage1Start;
  dir_mode_type overcurrent1DirectionMode;
  int mismatches, checkCount;
  preproc_model preproc_model_i (.*);
  general_protection_function #(.TICK_CYCLES(10)) general_protection_function_i (.*,
    .overcurrent1Block(blk[0]), .overcurrent1TripBlock(blk[1]),
    .overcurrent1MultiplierEnable(blk[2]), .overcurrent2Block(blk[3]),
    .overcurrent2TripBlock(blk[4]), .overcurrent2MultiplierEnable(blk[5]),
    .undercurrent1Block(blk[6]), .undercurrent1TripBlock(blk[7]), .undercurrent2Block(blk[8]),
    .undercurrent2TripBlock(blk[9]), .overvoltage1Block(blk[10]),
    .overvoltage1TripBlock(blk[11]), .overvoltage2Block(blk[12]),
    .overvoltage2TripBlock(blk[13]), .undervoltage1Block(blk[14]),
    .undervoltage1TripBlock(blk[15]), .undervoltage2Block(blk[16]),
    .undervoltage2TripBlock(blk[17]), .overcurrent1Trip(), .overcurrent2Trip(),
    .undercurrent1Trip(), .undercurrent2Trip(), .overvoltage2Trip(), .undervoltage1Trip(),
    .undervoltage2Trip(), .overcurrent1Start(), .overcurrent2Start(), .undercurrent1Start(),
    .undercurrent2Start(), .overvoltage2Start(), .undervoltage2Start(),
    .harmonicRestraintFlag(), .overcurrent2DirectionMode(), .polarizingVoltageLow(),
    .currentCosineProduct(), .voltageCurrentAngle());
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic wrapUp;
    if (mismatches == 0 && checkCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checkCount++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One classic cycle; holds until ack, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    @(posedge clk);
    while (ack_o !== 1'b1) @(posedge clk);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic regCheck;
    bus(1'b0, 8'h00, 32'h0);
    cmp(q, 32'h00002660);
    bus(1'b0, 8'h80, 32'h0);
    cmp(q[31:16], 16'h03F6);
    bus(1'b0, 8'hA0, 32'h0);
    cmp(q[31:16], 16'h040A);
    bus(1'b1, 8'h3C, 32'hFFFFFFFF);
    bus(1'b0, 8'h3C, 32'h0);
    cmp(q, 32'h0);
    bus(1'b1, 8'h00, 32'h00022661);
    repeat (2) @(posedge clk);
    cmp(overcurrent1DirectionMode, DIR_REVERSE);
    bus(1'b1, 8'h00, 32'h00032661);
    repeat (2) @(posedge clk);
    cmp(overcurrent1DirectionMode, DIR_NONDIR);
  endtask
  task automatic ovSteps;
    bus(1'b1, 8'h80, 32'h03F60064);
    bus(1'b1, 8'h84, 32'h00000003);
    bus(1'b1, 8'h88, 32'h00000001);
    vLevel <= 16'h0070;
    repeat (5) @(posedge clk);
    cmp(overvoltage1Start, 1'b1);
    cmp(overvoltage1Trip, 1'b0);
    cmp(measuredVoltage, 16'h0070);
    cmp(measuredCurrent, 16'h0123);
    repeat (60) if (overvoltage1Trip !== 1'b1) @(posedge clk);
    @(posedge clk);
    cmp(commonTrip, 1'b1);
    vLevel <= 16'h0064;
    repeat (5) @(posedge clk);
    cmp(overvoltage1Start, 1'b1);
    vLevel <= 16'h0050;
    repeat (5) @(posedge clk);
    cmp({overvoltage1Start, overvoltage1Trip}, 2'b00);
    blk[11] <= 1'b1;
    bus(1'b1, 8'h84, 32'h00020003);
    vLevel <= 16'h0070;
    repeat (60) @(posedge clk);
    cmp({overvoltage1Start, overvoltage1Trip}, 2'b10);
    vLevel <= 16'h0050;
    repeat (5) @(posedge clk);
    cmp(overvoltage1Start, 1'b1);
    repeat (40) @(posedge clk);
    cmp(overvoltage1Start, 1'b0);
    {blk[11], blk[10], vLevel} <= {2'b01, 16'h0070};
    repeat (5) @(posedge clk);
    cmp(overvoltage1Start, 1'b0);
    {blk[10], vLevel} <= {1'b0, 16'h0050};
  endtask
  task automatic uvSteps;
    bus(1'b1, 8'hA0, 32'h040A0040);
    bus(1'b1, 8'hA4, 32'h0);
    bus(1'b1, 8'hA8, 32'h00000001);
    vLevel <= 16'h0030;
    repeat (5) @(posedge clk);
    cmp({undervoltage1Start, commonStart}, 2'b11);
    globalBlock <= 1'b1;
    repeat (5) @(posedge clk);
    cmp({undervoltage1Start, commonStart}, 2'b00);
    globalBlock <= 1'b0;
    repeat (5) @(posedge clk);
    vLevel <= 16'h0040;
    repeat (30) @(posedge clk);
    cmp(undervoltage1Start, 1'b1);
    vLevel <= 16'h0041;
    repeat (5) @(posedge clk);
    cmp(undervoltage1Start, 1'b0);
  endtask
  initial begin
    {ce, sel_i, cyc_i, stb_i, we_i, adr_i, dat_i} = {1'b1, 4'hF, 43'h0};
    {arst_n, globalBlock, blk, vLevel, cLevel} = {20'h0, 16'h0050, 16'h0123};
    mismatches = 0;
    checkCount = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    regCheck();
    ovSteps();
    uvSteps();
    wrapUp();
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    wrapUp();
  end
endmodule
`default_nettype wire

// [sim/gpf_assertions.sv]
// Checks on step flags, common outputs and blocking.
// Assumes a bind onto general_protection_function; names match its ports.
`timescale 1ns/1ps
`default_nettype none
module gpf_assertions (
  input wire logic clk, arst_n, globalBlock, overvoltage1Block, overvoltage1TripBlock,
  input wire logic commonStart, commonTrip, overvoltage1Start, overvoltage1Trip,
  input wire logic undervoltage1Start, undervoltage1Trip,
  input var gpf_pkg::dir_mode_type overcurrent1DirectionMode
);
  import gpf_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ov_common_a: assert property (overvoltage1Start && !globalBlock |=> commonStart)
    else $error("common start missing");
  uv_common_a: assert property (undervoltage1Trip && !globalBlock |=> commonTrip)
    else $error("common trip missing");
  global_clear_a: assert property (globalBlock[*3] |->
    !(overvoltage1Start || undervoltage1Start || overvoltage1Trip)) else $error("not cleared");
  global_common_a: assert property (globalBlock[*4] |-> !commonStart && !commonTrip)
    else $error("common flag under block");
  trip_mask_a: assert property (overvoltage1TripBlock[*3] |-> !overvoltage1Trip)
    else $error("trip not masked");
  own_block_a: assert property (overvoltage1Block[*3] |-> !overvoltage1Start)
    else $error("blocked step started");
  ov_trip_start_a: assert property ($rose(overvoltage1Trip) |-> overvoltage1Start)
    else $error("trip without start");
  uv_trip_start_a: assert property ($rose(undervoltage1Trip) |-> undervoltage1Start)
    else $error("trip without start");
  dir_code_a: assert property (2'(overcurrent1DirectionMode) != 2'h3)
    else $error("bad direction code");
endmodule
bind general_protection_function gpf_assertions gpf_assertions_i (.*);
`default_nettype wire

// [sim/preproc_model.sv]
// Stand-in for the upstream pre-processing: phase and sequence magnitudes.
// Assumes the block's clock; the maximum phase carries the requested level.
`timescale 1ns/1ps
`default_nettype none
module preproc_model (
  input wire logic clk,
  input wire logic [15:0] vLevel,
  input wire logic [15:0] cLevel,
  output logic [15:0] currPh1, currPh2, currPh3, currPos, currNeg, currZero3,
  output logic [15:0] voltPh1, voltPh2, voltPh3, voltPos, voltNeg, voltZero3,
  output logic [15:0] curr2ndHarm, cosAngle, angleIn
);
  // One current set and one voltage set, primary units
  always_ff @(posedge clk) begin
    {voltPh1, voltPh2, voltPh3} <= {vLevel >> 2, vLevel, vLevel >> 1};
    {voltPos, voltNeg, voltZero3} <= {vLevel >> 1, 32'h0};
    {currPh1, currPh2, currPh3} <= {cLevel, cLevel >> 1, cLevel >> 3};
    {currPos, currNeg, currZero3} <= {cLevel >> 1, 32'h0};
    {curr2ndHarm, cosAngle, angleIn} <= {16'h0000, 16'h4000, 16'h1234};
  end
endmodule
`default_nettype wire
